// ===== rtl/vpr_alias_read.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpr_map.svh"

module vpr_alias_read
(
    input wire logic [31:0] acc, // Stored acceleration
    input wire logic [31:0] dec, // Stored deceleration
    output logic [15:0] value // Scaled, saturated alias value
);
    wire logic [31:0] larger = (acc > dec) ? acc : dec;
    wire logic [31:0] scaled = larger / `VPR_SYM_FACTOR;

    // Anything above 16 bits pins at the ceiling
    assign value = (scaled[31:16] != 16'h0000) ? `VPR_SYM_SAT : scaled[15:0];

endmodule // vpr_alias_read
`default_nettype wire

// ===== rtl/vpr_map.svh
`ifndef VPR_MAP_SVH
`define VPR_MAP_SVH

// ****************************************
// Parameter numbers
// ****************************************
`define VPR_OFS_SYM 16'h0602
`define VPR_OFS_VMAX 16'h0612
`define VPR_OFS_ACC 16'h0614
`define VPR_OFS_DEC 16'h0616
`define VPR_OFS_JERK 16'h061A
`define VPR_OFS_PEN 16'h0656

// ****************************************
// Reset values and limits
// ****************************************
`define VPR_RST_VMAX 32'h0000_3390
`define VPR_RST_ACC 32'h0000_0258
`define VPR_RST_DEC 32'h0000_0258
`define VPR_RST_JERK 16'h0000
`define VPR_RST_PEN 16'h0001
`define VPR_MAX_U31 32'h7FFF_FFFF
`define VPR_DEC_MIN_FAST 32'h0000_0001
`define VPR_DEC_MIN_SLOW 32'h0000_0078
`define VPR_SYM_FACTOR 32'h0000_000A
`define VPR_SYM_SAT 16'hFFFF
`define VPR_JERK_MAX 16'h0080

// ****************************************
// Timing
// ****************************************
`define VPR_CLK_NS 4
`define VPR_UPD_NS 1000
`define VPR_UPD_CYC ((`VPR_UPD_NS + `VPR_CLK_NS - 1) / `VPR_CLK_NS)

`endif

// ===== rtl/vpr_params.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpr_map.svh"

// Notes on behaviour
// - Acceleration write of zero is ignored; valid from 1, default 600.
// - Deceleration minimum is 1 in velocity modes, 120 otherwise; zero ignored.
// - New acceleration and deceleration take effect at the next motion start.
// - Profile enable 0 bypasses the velocity profile, 1 activates it; default 1.
// - Profile enable changes only with power stage off, effective at once.
// - Jerk setting 0 is off; 1 to 128 powers of two give milliseconds.
// - Jerk setting changes only while mode is finished; applies at next start.
// - Reference speed is clamped to the maximum velocity, default 13200.
// - Maximum velocity changes only with power stage off; applies at next start.
// - Alias write stores value times ten in both ramps, checked against limits.
// - Alias read returns the larger of both ramps divided by ten.
// - Alias read saturates at 65535 when it exceeds 16 bits.

module vpr_params
    import vpr_pkg::*;
#(
    parameter int UPD_CYC = `VPR_UPD_CYC
)
(
    input wire logic clk, // Drive clock, 250 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire vpr_req_type par_req, // Parameter read or write request
    output vpr_rsp_type par_rsp, // Registered answer
    input wire logic power_en, // Power stage enabled
    input wire logic mode_end, // Operating mode finished
    input wire vpr_mode_type op_mode, // Current operating mode
    input wire logic motion_start, // Pulse at start of a motion
    input wire logic signed [31:0] target_vel, // Requested reference speed
    output logic signed [31:0] vel_ref, // Velocity reference to power stage
    output logic profile_active, // Velocity profile in use
    output logic [15:0] jerk_ms // Active jerk filter time, 0 is off
);
    // ****************************************
    // Stored and active settings
    // ****************************************
    vpr_set_type set_q;
    vpr_set_type act_q;
    logic [15:0] pen_q;
    vpr_rsp_type rsp_q;

    // ****************************************
    // Request decode
    // ****************************************
    wire logic wr = par_req.wr;
    wire logic rd = par_req.rd & ~par_req.wr;
    wire logic [31:0] wd = par_req.wdata;
    wire logic hit_sym = (par_req.addr == `VPR_OFS_SYM);
    wire logic hit_vmax = (par_req.addr == `VPR_OFS_VMAX);
    wire logic hit_acc = (par_req.addr == `VPR_OFS_ACC);
    wire logic hit_dec = (par_req.addr == `VPR_OFS_DEC);
    wire logic hit_jerk = (par_req.addr == `VPR_OFS_JERK);
    wire logic hit_pen = (par_req.addr == `VPR_OFS_PEN);
    wire logic hit_any = hit_sym | hit_vmax | hit_acc | hit_dec | hit_jerk | hit_pen;

    // Position-style modes need a higher floor on braking
    wire logic slow_mode = !(op_mode == VPR_GEAR_VEL || op_mode == VPR_PROF_VEL
        || op_mode == VPR_SEQ_VEL);
    wire logic [31:0] dec_min = slow_mode ? `VPR_DEC_MIN_SLOW : `VPR_DEC_MIN_FAST;

    wire logic [31:0] sym_x10 = {16'h0000, wd[15:0]} * `VPR_SYM_FACTOR;
    wire logic wd_zero = (wd == 32'h0000_0000);
    wire logic sym_zero = (wd[15:0] == 16'h0000);
    wire logic acc_ok = (wd <= `VPR_MAX_U31);
    wire logic dec_ok = (wd <= `VPR_MAX_U31) && (wd >= dec_min);
    wire logic sym_ok = (sym_x10 >= dec_min);
    wire logic vmax_ok = (wd <= `VPR_MAX_U31) && !power_en;
    wire logic jerk_val = (wd[31:8] == 24'h00_0000) && ((wd[7:0] & (wd[7:0] - 8'h01)) == 8'h00);
    wire logic jerk_ok = jerk_val && mode_end;
    wire logic pen_ok = (wd[31:1] == 31'h0000_0000) && !power_en;

    // Zero writes to acceleration, deceleration, velocity limit and alias are dropped silently, other refusals raise err
    wire logic wr_acc = wr && hit_acc && !wd_zero && acc_ok;
    wire logic wr_dec = wr && hit_dec && !wd_zero && dec_ok;
    wire logic wr_sym = wr && hit_sym && !sym_zero && sym_ok;
    wire logic wr_vmax = wr && hit_vmax && !wd_zero && vmax_ok;
    wire logic wr_jerk = wr && hit_jerk && jerk_ok;
    wire logic wr_pen = wr && hit_pen && pen_ok;

    wire logic wr_bad = wr && (!hit_any
        || (hit_acc && !wd_zero && !acc_ok)
        || (hit_dec && !wd_zero && !dec_ok)
        || (hit_sym && !sym_zero && !sym_ok)
        || (hit_vmax && !wd_zero && !vmax_ok)
        || (hit_jerk && !jerk_ok)
        || (hit_pen && !pen_ok));

    // ****************************************
    // Read path
    // ****************************************
    logic [15:0] sym_rd;

    vpr_alias_read u_alias
    (
        .acc(set_q.acc),
        .dec(set_q.dec),
        .value(sym_rd)
    );

    wire logic [31:0] rd_data =
        hit_sym ? {16'h0000, sym_rd} :
        hit_vmax ? set_q.vmax :
        hit_acc ? set_q.acc :
        hit_dec ? set_q.dec :
        hit_jerk ? {16'h0000, set_q.jerk} :
        hit_pen ? {16'h0000, pen_q} : 32'h0000_0000;

    // ****************************************
    // Next values
    // ****************************************
    vpr_set_type set_d;

    always_comb
    begin
        set_d = set_q;
        if (wr_acc)
            set_d.acc = wd;
        if (wr_dec)
            set_d.dec = wd;
        if (wr_sym)
        begin
            set_d.acc = sym_x10;
            set_d.dec = sym_x10;
        end
        if (wr_vmax)
            set_d.vmax = wd;
        if (wr_jerk)
            set_d.jerk = wd[15:0];
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            set_q <= '{acc: `VPR_RST_ACC, dec: `VPR_RST_DEC,
                vmax: `VPR_RST_VMAX, jerk: `VPR_RST_JERK};
            pen_q <= `VPR_RST_PEN;
            rsp_q <= '0;
        end
        else
        begin
            set_q <= set_d;
            if (wr_pen)
                pen_q <= wd[15:0];
            rsp_q.ack <= wr | rd;
            rsp_q.err <= wr_bad | (rd & !hit_any);
            rsp_q.rdata <= rd ? rd_data : 32'h0000_0000;
        end
    end

    // A motion in flight keeps the ramp it started with
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            act_q <= '{acc: `VPR_RST_ACC, dec: `VPR_RST_DEC,
                vmax: `VPR_RST_VMAX, jerk: `VPR_RST_JERK};
        else if (motion_start)
            act_q <= set_q;
    end

    // ****************************************
    // Clamp and ramp
    // ****************************************
    wire logic signed [31:0] vlim = $signed(act_q.vmax);
    wire logic signed [31:0] tgt_c = (target_vel > vlim) ? vlim
        : (target_vel < -vlim) ? -vlim : target_vel;

    vpr_ramp_gen #(
        .UPD_CYC(UPD_CYC)
    ) u_ramp
    (
        .clk(clk),
        .rst_b(rst_b),
        .prof_en(pen_q[0]),
        .target(tgt_c),
        .acc(act_q.acc),
        .dec(act_q.dec),
        .vel_ref(vel_ref)
    );

    assign par_rsp = rsp_q;
    assign profile_active = pen_q[0];
    assign jerk_ms = act_q.jerk;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_zero_wr(logic hit);
        wr && hit && wd_zero;
    endsequence

    sequence s_sym_wr;
        wr && hit_sym && !sym_zero && sym_ok;
    endsequence

    acc_zero_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_zero_wr(hit_acc) |=> set_q.acc == $past(set_q.acc) && !par_rsp.err)
        else $error("zero write altered acceleration");

    dec_floor_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr && hit_dec && slow_mode && !wd_zero && wd < 32'h0000_0078
        |=> $stable(set_q.dec) && par_rsp.err)
        else $error("deceleration below 120 accepted");

    act_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        !motion_start |=> act_q == $past(act_q))
        else $error("active ramp changed mid motion");

    pen_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
        power_en |=> pen_q == $past(pen_q))
        else $error("profile enable changed with power on");

    pen_now_a: assert property (@(posedge clk) disable iff (!rst_b)
        wr && hit_pen && !power_en && wd == 32'h0000_0000 |=> !profile_active)
        else $error("profile off not immediate");

    jerk_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        set_q.jerk <= `VPR_JERK_MAX && (set_q.jerk & (set_q.jerk - 16'h0001)) == 16'h0000)
        else $error("jerk setting not a legal time");

    jerk_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
        !mode_end |=> $stable(set_q.jerk))
        else $error("jerk changed while mode active");

    clamp_lim_a: assert property (@(posedge clk) disable iff (!rst_b)
        tgt_c <= vlim && tgt_c >= -vlim)
        else $error("target exceeds velocity limit");

    vmax_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
        power_en |=> $stable(set_q.vmax))
        else $error("velocity limit changed with power on");

    sym_store_a: assert property (@(posedge clk) disable iff (!rst_b)
        s_sym_wr |=> set_q.acc == $past(sym_x10) && set_q.dec == $past(sym_x10))
        else $error("alias write not stored times ten");

    sym_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd && hit_sym && set_q.acc == set_q.dec && set_q.acc < 32'h0009_FFF6
        |=> par_rsp.rdata == $past(set_q.acc) / 32'h0000_000A)
        else $error("alias read wrong");

    sym_sat_a: assert property (@(posedge clk) disable iff (!rst_b)
        rd && hit_sym && (set_q.acc > 32'h000A_0000 || set_q.dec > 32'h000A_0000)
        |=> par_rsp.rdata == 32'h0000_FFFF)
        else $error("alias read not saturated");

endmodule // vpr_params
`default_nettype wire

// ===== rtl/vpr_pkg.sv
package vpr_pkg;

    typedef enum logic [2:0] {
        VPR_GEAR_VEL = 3'b000,
        VPR_PROF_VEL = 3'b001,
        VPR_SEQ_VEL = 3'b010,
        VPR_JOG = 3'b011,
        VPR_PROF_POS = 3'b100,
        VPR_HOMING = 3'b101,
        VPR_SEQ_MOVE = 3'b110,
        VPR_OTHER = 3'b111
    } vpr_mode_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [31:0] wdata;
    } vpr_req_type;

    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } vpr_rsp_type;

    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] dec;
        logic [31:0] vmax;
        logic [15:0] jerk;
    } vpr_set_type;

endpackage

// ===== rtl/vpr_ramp_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpr_map.svh"

module vpr_ramp_gen
#(
    parameter int UPD_CYC = `VPR_UPD_CYC
)
(
    input wire logic clk, // Drive clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic prof_en, // Profile active
    input wire logic signed [31:0] target, // Clamped target velocity
    input wire logic [31:0] acc, // Active acceleration step
    input wire logic [31:0] dec, // Active deceleration step
    output logic signed [31:0] vel_ref // Velocity reference
);
    logic [15:0] tick_q;
    logic signed [31:0] ref_q;

    wire logic tick = (tick_q == 16'(UPD_CYC - 1));
    wire logic signed [32:0] diff = 33'(target) - 33'(ref_q);
    wire logic up = (diff > 33'sd0);
    // Away from zero is acceleration, toward zero is braking
    wire logic speeding = up ? (ref_q >= 32'sd0) : (ref_q <= 32'sd0);
    wire logic [32:0] step = {1'b0, (speeding ? acc : dec)};
    wire logic [32:0] mag = up ? 33'(diff) : 33'(-diff);
    wire logic signed [31:0] ref_d = (!prof_en || mag <= step) ? target
        : (up ? ref_q + 32'(step) : ref_q - 32'(step));

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tick_q <= 16'h0000;
            ref_q <= 32'sh0000_0000;
        end
        else
        begin
            tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
            if (tick || !prof_en)
                ref_q <= ref_d;
        end
    end

    assign vel_ref = ref_q;

    // ****************************************
    // Checks
    // ****************************************
    ramp_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        prof_en && ref_q == target && $stable(target) ##1 prof_en |-> ref_q == $past(ref_q))
        else $error("reference moved after reaching target");
    ramp_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        prof_en && tick && mag > step |=> ref_q != $past(ref_q))
        else $error("reference did not step toward target");

endmodule // vpr_ramp_gen
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import vpr_pkg::*;
    localparam int UPD = 4;
    logic clk, rst_b, power_en, mode_end, motion_start, profile_active;
    logic ack, er;
    logic [31:0] rd;
    logic [15:0] jerk_ms;
    logic signed [31:0] target_vel, vel_ref, prev_ref;
    vpr_mode_type op_mode;
    vpr_req_type par_req;
    vpr_rsp_type par_rsp;
    int errors = 0;
    int num_checks = 0;
    int i;
    longint m_acc = 600, m_dec = 600, m_vmax = 13200, m_jerk = 0, m_pen = 1;
    longint a_step = 600;
    longint v, dl;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    vpr_params #(.UPD_CYC(UPD)) dut_u (.clk(clk), .rst_b(rst_b), .par_req(par_req),
        .par_rsp(par_rsp), .power_en(power_en), .mode_end(mode_end), .op_mode(op_mode),
        .motion_start(motion_start), .target_vel(target_vel), .vel_ref(vel_ref),
        .profile_active(profile_active), .jerk_ms(jerk_ms));

    vpr_bus_master master_u (.clk(clk), .par_req(par_req), .par_rsp(par_rsp));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d num_checks=%0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic longint alias_exp();
        longint m;
        m = ((m_acc > m_dec) ? m_acc : m_dec) / 10;
        return (m > 65535) ? 65535 : m;
    endfunction

    // Reference model of the write side, then one bus write
    task automatic put(input logic [15:0] a, input longint d);
        longint f;
        logic x;
        f = (op_mode < 3) ? 1 : 120;
        x = 1'b0;
        case (a)
            16'h0614: if (d > 32'h7fff_ffff) x = 1'b1; else if (d != 0) m_acc = d;
            16'h0616: if (d != 0 && (d < f || d > 32'h7fff_ffff)) x = 1'b1;
                else if (d != 0) m_dec = d;
            16'h0602: if (d != 0 && d * 10 < f) x = 1'b1;
                else if (d != 0) {m_acc, m_dec} = {d * 10, d * 10};
            16'h0612: if (d != 0 && (power_en || d > 32'h7fff_ffff)) x = 1'b1;
                else if (d != 0) m_vmax = d;
            16'h061A: if (!mode_end || !(d inside {0, 1, 2, 4, 8, 16, 32, 64, 128})) x = 1'b1;
                else m_jerk = d;
            16'h0656: if (power_en || d > 1) x = 1'b1; else m_pen = d;
            default: x = 1'b1;
        endcase
        master_u.access(1'b1, a, d[31:0], ack, er, rd);
        check("ack", 1, {31'h0, ack});
        check("err", {31'h0, x}, {31'h0, er});
    endtask

    task automatic get(input logic [15:0] a, input longint e);
        master_u.access(1'b0, a, 32'h0000_0000, ack, er, rd);
        check("ack", 1, {31'h0, ack});
        check("rdata", e[31:0], rd);
    endtask

    // Target moves only once the new ramp is latched, so no step mixes old and new settings
    task automatic start(input logic signed [31:0] t);
        @(negedge clk);
        motion_start = 1'b1;
        a_step <= (m_acc > m_dec) ? m_acc : m_dec;
        @(negedge clk);
        motion_start = 1'b0;
        target_vel = t;
    endtask

    task automatic settle(input logic signed [31:0] t);
        int n;
        n = 0;
        while (vel_ref !== t && n < 6000)
        begin
            @(negedge clk);
            n++;
        end
        check("vel_ref", t, vel_ref);
    endtask

    // ****************************************
    // Ramp step monitor
    // ****************************************
    // A step larger than the latched ramp means a mid-motion write leaked in
    always @(negedge clk)
    begin
        if (rst_b === 1'b1 && profile_active === 1'b1 && vel_ref !== prev_ref)
        begin
            dl = longint'(vel_ref) - longint'(prev_ref);
            check("step", 1, {31'h0, (dl <= a_step && -dl <= a_step)});
        end
        prev_ref <= vel_ref;
    end

    initial
    begin
        #(60000 * 4);
        errors++;
        finish_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {rst_b, power_en, motion_start} = 3'b000;
        mode_end = 1'b1;
        op_mode = VPR_PROF_VEL;
        target_vel = 0;
        prev_ref = 0;
        v = $urandom(32'h0308_8be1);
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        get(16'h0614, 600);
        get(16'h0616, 600);
        get(16'h0612, 13200);
        get(16'h061A, 0);
        get(16'h0656, 1);
        get(16'h0602, 60);
        get(16'h0600, 0);
        put(16'h0614, 0);
        get(16'h0614, m_acc);
        for (i = 0; i < 8; i++)
        begin
            op_mode = vpr_mode_type'(i);
            put(16'h0616, 1);
            put(16'h0616, 119);
            put(16'h0616, 120);
            put(16'h0616, 0);
            get(16'h0616, m_dec);
        end
        put(16'h0602, 11);
        op_mode = VPR_PROF_VEL;
        put(16'h0602, $urandom_range(1, 2000));
        get(16'h0614, m_acc);
        get(16'h0616, m_dec);
        get(16'h0602, alias_exp());
        put(16'h0614, 64'h8000_0000);
        put(16'h0614, 32'h7fff_ffff);
        get(16'h0602, alias_exp());
        mode_end = 1'b0;
        put(16'h061A, 8);
        mode_end = 1'b1;
        for (i = 0; i < 9; i++)
            put(16'h061A, (i == 0) ? 0 : (1 << (i - 1)));
        put(16'h061A, 3);
        put(16'h061A, 32);
        check("jerk_ms", 0, {16'h0, jerk_ms});
        start(0);
        check("jerk_ms", 32, {16'h0, jerk_ms});
        power_en = 1'b1;
        put(16'h0656, 0);
        put(16'h0612, 500);
        check("profile_active", 1, {31'h0, profile_active});
        power_en = 1'b0;
        put(16'h0656, 2);
        put(16'h0656, 0);
        check("profile_active", 0, {31'h0, profile_active});
        v = $urandom_range(100, 400);
        put(16'h0612, v);
        get(16'h0612, m_vmax);
        start(32'(v + 300));
        @(negedge clk);
        check("clamp", v[31:0], vel_ref);
        target_vel = 32'(-(v + 300));
        repeat (2) @(negedge clk);
        check("clamp", 32'(-v), vel_ref);
        put(16'h0656, 1);
        power_en = 1'b1;
        v = $urandom_range(4, 9);
        put(16'h0614, v);
        put(16'h0616, v);
        start(32'(m_vmax + 50));
        settle(m_vmax[31:0]);
        start(0);
        put(16'h0602, 100);
        settle(0);
        finish_test();
    end
endmodule // tb

`default_nettype wire

// ===== verification/vpr_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module vpr_bus_master
    import vpr_pkg::*;
(
    input wire logic clk, // Drive clock
    output var vpr_req_type par_req, // Request to the parameter block
    input wire vpr_rsp_type par_rsp // Registered answer
);
    initial par_req = '0;

    // Released address and data are inverted so that stale values cannot pass for good ones
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                          output logic ack, output logic err, output logic [31:0] rdata);
        @(negedge clk);
        par_req.rd = ~wr;
        par_req.wr = wr;
        par_req.addr = addr;
        par_req.wdata = wdata;
        @(negedge clk);
        ack = par_rsp.ack;
        err = par_rsp.err;
        rdata = par_rsp.rdata;
        par_req.rd = 1'b0;
        par_req.wr = 1'b0;
        par_req.addr = ~addr;
        par_req.wdata = ~wdata;
    endtask
endmodule // vpr_bus_master

`default_nettype wire
